// file: hw/dbm_top.sv
// Bus-master output signalling of a four-channel DMA controller
`default_nettype none
module dbm_top #(
  parameter int CHANNELS = dbm_pkg::DBM_CHANNELS
) (
  input wire logic sys_clk_in, // 40 MHz clock
  input wire logic arst_n_in, // Async reset, active low
  input wire logic [CHANNELS-1:0] channel_request_in, // Pins, async
  input wire logic bus_hold_grant_in, // Grant from host, async
  input wire dbm_pkg::dbm_ctrl_t ctrl_in, // Internal control, same clock
  input wire dbm_pkg::dbm_addr_t addr_in, // Address of this cycle
  input wire logic service_end_in, // Internal end of service
  output logic bus_hold_request_out, // Hold request
  output logic [CHANNELS-1:0] channel_acknowledge_out, // Per channel
  output logic upper_address_enable_out, // Active high
  output logic upper_address_strobe_out, // Active high, falling-edge
  output logic [dbm_pkg::DBM_MID_ADDR_W-1:0] middle_address_out, // Addr
  output logic middle_address_oe_out, // High while driving
  output logic memory_read_strobe_n_out, // Active low
  output logic memory_write_strobe_n_out, // Active low
  output logic mem_strobe_oe_out // High while driving strobes
);
  // ==========================================================
  // Input synchronisers
  logic [CHANNELS-1:0] req_s1_r, req_s2_r;
  logic grant_s1_r, grant_s2_r;
  logic [CHANNELS-1:0] req_fall_r;

  always_ff @(negedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_s1_r <= '0;
      req_s2_r <= '0;
    end else begin
      req_s1_r <= channel_request_in;
      req_s2_r <= req_s1_r;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      grant_s1_r <= 1'b0;
      grant_s2_r <= 1'b0;
      req_fall_r <= '0;
    end else begin
      grant_s1_r <= bus_hold_grant_in;
      grant_s2_r <= grant_s1_r;
      req_fall_r <= req_s2_r;
    end
  end

  // ==========================================================
  // Request decode
  function automatic logic [CHANNELS-1:0] first_one(
    input logic [CHANNELS-1:0] v);
    logic [CHANNELS-1:0] r;
    r = '0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  wire logic [CHANNELS-1:0] pending =
    (req_fall_r & ~ctrl_in.mask[CHANNELS-1:0]) |
    ctrl_in.soft_req[CHANNELS-1:0];
  wire logic any_pending = |pending;
  wire logic [CHANNELS-1:0] pick = first_one(pending);

  // ==========================================================
  // State machine
  dbm_pkg::dbm_state_t state_r, state_nxt;
  logic [CHANNELS-1:0] chan_r, chan_nxt;
  logic [dbm_pkg::DBM_UPPER_W-1:0] last_upper_r;
  logic upper_valid_r;
  logic strobe_req_r;
  logic ack_high_r;

  wire logic upper_changed =
    !upper_valid_r || (addr_in.upper != last_upper_r);
  wire logic is_m2m = (ctrl_in.xfer == dbm_pkg::DBM_XFER_MEM2MEM);
  wire logic do_read = is_m2m || (ctrl_in.xfer == dbm_pkg::DBM_XFER_READ);
  wire logic do_write = is_m2m || (ctrl_in.xfer == dbm_pkg::DBM_XFER_WRITE);
  wire logic in_service = (state_r != dbm_pkg::DBM_ST_IDLE) &&
    (state_r != dbm_pkg::DBM_ST_HOLD_WAIT);

  always_comb begin
    state_nxt = state_r;
    chan_nxt = chan_r;
    unique case (state_r)
      dbm_pkg::DBM_ST_IDLE: begin
        if (any_pending) begin
          state_nxt = dbm_pkg::DBM_ST_HOLD_WAIT;
          chan_nxt = pick;
        end
      end
      dbm_pkg::DBM_ST_HOLD_WAIT: begin
        if (grant_s2_r) begin
          state_nxt = upper_changed ? dbm_pkg::DBM_ST_ADDR_UPDATE :
            dbm_pkg::DBM_ST_READ;
        end
      end
      dbm_pkg::DBM_ST_ADDR_UPDATE: state_nxt = dbm_pkg::DBM_ST_READ;
      dbm_pkg::DBM_ST_READ: state_nxt = dbm_pkg::DBM_ST_WRITE;
      dbm_pkg::DBM_ST_WRITE: begin
        if (service_end_in || !grant_s2_r) begin
          state_nxt = dbm_pkg::DBM_ST_DONE;
        end else if (upper_changed) begin
          state_nxt = dbm_pkg::DBM_ST_ADDR_UPDATE;
        end else begin
          state_nxt = dbm_pkg::DBM_ST_READ;
        end
      end
      dbm_pkg::DBM_ST_DONE: begin
        state_nxt = dbm_pkg::DBM_ST_IDLE;
        chan_nxt = '0;
      end
      default: begin
        state_nxt = dbm_pkg::DBM_ST_IDLE;
        chan_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= dbm_pkg::DBM_ST_IDLE;
      chan_r <= '0;
    end else begin
      state_r <= state_nxt;
      chan_r <= chan_nxt;
    end
  end

  // ==========================================================
  // Upper address tracking and strobe
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      last_upper_r <= '0;
      upper_valid_r <= 1'b0;
    end else if (state_r == dbm_pkg::DBM_ST_ADDR_UPDATE) begin
      last_upper_r <= addr_in.upper;
      upper_valid_r <= 1'b1;
    end else if (state_r == dbm_pkg::DBM_ST_IDLE) begin
      upper_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strobe_req_r <= 1'b0;
    end else begin
      strobe_req_r <= (state_nxt == dbm_pkg::DBM_ST_ADDR_UPDATE);
    end
  end

  always_ff @(negedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      upper_address_strobe_out <= 1'b0;
    end else begin
      upper_address_strobe_out <= strobe_req_r;
    end
  end

  // ==========================================================
  // Acknowledge polarity, taken from control while idle, held during service
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_high_r <= dbm_pkg::DBM_ACK_ACTIVE_HIGH_RST;
    end else if (state_r == dbm_pkg::DBM_ST_IDLE) begin
      ack_high_r <= ctrl_in.ack_high;
    end
  end

  // ==========================================================
  // Output registers
  wire logic hold_nxt = (state_nxt != dbm_pkg::DBM_ST_IDLE) &&
    (state_nxt != dbm_pkg::DBM_ST_DONE);
  wire logic svc_nxt = (state_nxt == dbm_pkg::DBM_ST_ADDR_UPDATE) ||
    (state_nxt == dbm_pkg::DBM_ST_READ) ||
    (state_nxt == dbm_pkg::DBM_ST_WRITE);
  wire logic [CHANNELS-1:0] ack_act = svc_nxt ? chan_nxt : '0;
  wire logic ack_pol_nxt = (state_r == dbm_pkg::DBM_ST_IDLE) ?
    ctrl_in.ack_high : ack_high_r;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_hold_request_out <= 1'b0;
      channel_acknowledge_out <= '1;
      upper_address_enable_out <= 1'b0;
      middle_address_out <= '0;
      middle_address_oe_out <= 1'b0;
      memory_read_strobe_n_out <= 1'b1;
      memory_write_strobe_n_out <= 1'b1;
      mem_strobe_oe_out <= 1'b0;
    end else begin
      bus_hold_request_out <= hold_nxt;
      channel_acknowledge_out <= ack_pol_nxt ? ack_act : ~ack_act;
      upper_address_enable_out <= svc_nxt;
      middle_address_out <= svc_nxt ? addr_in.middle : '0;
      middle_address_oe_out <= svc_nxt;
      memory_read_strobe_n_out <=
        !((state_nxt == dbm_pkg::DBM_ST_READ) && do_read);
      memory_write_strobe_n_out <=
        !((state_nxt == dbm_pkg::DBM_ST_WRITE) && do_write);
      mem_strobe_oe_out <= svc_nxt;
    end
  end

  wire logic unused_ok = in_service;
endmodule : dbm_top
`default_nettype wire

// file: hw/dbm_pkg.sv
// Package for the DMA bus-master signalling block
// Overview of operation
// - Middle address outputs drive four bits only during service, else released.
// - Raise hold request on unmasked channel request or software request.
// - Wait for hold grant before taking the busses.
// - Hold request looped to grant costs exactly three clocks in the hold wait state.
// - One acknowledge per channel; polarity programmable, active low after reset.
// - Upper address enable high throughout DMA transfers.
// - Upper address strobe at the start of each service and when upper byte changes; else skip update.
// - Upper address strobe changes on the falling clock edge.
// - Memory read strobe, active low, for read and memory-to-memory transfers.
// - Memory write strobe, active low, for write and memory-to-memory.
// - Sample channel requests on every falling edge, in every state; act on them only while idle.
`default_nettype none
package dbm_pkg;
  localparam int DBM_CHANNELS = 4;
  localparam int DBM_MID_ADDR_W = 4;
  localparam int DBM_UPPER_W = 8;
  localparam logic DBM_ACK_ACTIVE_HIGH_RST = 1'b0;

  // Transfer types
  typedef enum logic [1:0] {
    DBM_XFER_VERIFY = 2'h0,
    DBM_XFER_WRITE = 2'h1,
    DBM_XFER_READ = 2'h2,
    DBM_XFER_MEM2MEM = 2'h3
  } dbm_xfer_t;

  // Gray-coded states along the usual path
  typedef enum logic [2:0] {
    DBM_ST_IDLE = 3'h0,
    DBM_ST_HOLD_WAIT = 3'h1,
    DBM_ST_ADDR_UPDATE = 3'h3,
    DBM_ST_READ = 3'h2,
    DBM_ST_WRITE = 3'h6,
    DBM_ST_DONE = 3'h7
  } dbm_state_t;

  // Service request from internal control
  typedef struct packed {
    logic [DBM_CHANNELS-1:0] mask;
    logic [DBM_CHANNELS-1:0] soft_req;
    dbm_xfer_t xfer;
    logic ack_high;
  } dbm_ctrl_t;

  // Address presented for the current cycle
  typedef struct packed {
    logic [DBM_UPPER_W-1:0] upper;
    logic [DBM_MID_ADDR_W-1:0] middle;
  } dbm_addr_t;
endpackage : dbm_pkg
`default_nettype wire

// file: tb/dbm_chk.sv
// Concurrent checks on the bus-master signalling ports
`default_nettype none
module dbm_chk #(
  parameter int CHANNELS = 4
) (
  input wire logic sys_clk_in, // Clock
  input wire logic arst_n_in, // Reset, active low
  input wire logic [CHANNELS-1:0] channel_request_in, // Requests
  input wire dbm_pkg::dbm_ctrl_t ctrl_in, // Control
  input wire logic bus_hold_grant_in, // Grant
  input wire logic bus_hold_request_out, // Hold request
  input wire logic [CHANNELS-1:0] channel_acknowledge_out, // Acks
  input wire logic upper_address_enable_out, // Enable
  input wire logic upper_address_strobe_out, // Strobe
  input wire logic middle_address_oe_out, // Address drive
  input wire logic memory_read_strobe_n_out, // Read strobe
  input wire logic memory_write_strobe_n_out, // Write strobe
  input wire logic mem_strobe_oe_out // Strobe drive
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // Helpers
  wire [CHANNELS-1:0] act = channel_acknowledge_out ^
    {CHANNELS{~ctrl_in.ack_high}};
  wire cause = |(channel_request_in & ~ctrl_in.mask) | |ctrl_in.soft_req;
  logic [2:0] since_r;
  logic str_r;
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      since_r <= 3'h7;
      str_r <= 1'b0;
    end else begin
      since_r <= cause ? 3'h0 : since_r + {2'h0, since_r != 3'h7};
      str_r <= upper_address_strobe_out;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence pulse_s;
    $rose(upper_address_strobe_out) ##1 !upper_address_strobe_out;
  endsequence
  // ==========
  // Assertions
  mid_drive_a: assert property (middle_address_oe_out |->
    bus_hold_request_out && upper_address_enable_out) else $error("mid");
  hold_cause_a: assert property ($rose(bus_hold_request_out) |->
    since_r <= 3'h4) else $error("hold without cause");
  grant_first_a: assert property ($rose(upper_address_enable_out) |->
    $past(bus_hold_grant_in, 2)) else $error("bus taken early");
  ack_one_a: assert property (upper_address_enable_out |->
    $onehot(act)) else $error("ack not one");
  strobe_en_a: assert property (upper_address_strobe_out |->
    upper_address_enable_out) else $error("strobe without enable");
  strobe_edge_a: assert property (@(negedge sys_clk_in)
    upper_address_strobe_out == str_r) else $error("strobe edge");
  strobe_once_a: assert property (@(negedge sys_clk_in)
    $rose(upper_address_strobe_out) |-> pulse_s) else $error("strobe long");
  idle_quiet_a: assert property (!bus_hold_request_out |->
    !upper_address_enable_out && !mem_strobe_oe_out &&
    memory_read_strobe_n_out && memory_write_strobe_n_out)
    else $error("drive in idle");
  mem_read_a: assert property (!memory_read_strobe_n_out |->
    mem_strobe_oe_out && ctrl_in.xfer[1]) else $error("bad read");
  mem_write_a: assert property (!memory_write_strobe_n_out |->
    mem_strobe_oe_out && ctrl_in.xfer[0]) else $error("bad write");
endmodule // dbm_chk
bind dbm_top dbm_chk #(.CHANNELS(CHANNELS)) i_chk (.sys_clk_in, .arst_n_in,
  .channel_request_in, .ctrl_in, .bus_hold_grant_in, .bus_hold_request_out,
  .channel_acknowledge_out, .upper_address_enable_out,
  .upper_address_strobe_out, .middle_address_oe_out,
  .memory_read_strobe_n_out, .memory_write_strobe_n_out, .mem_strobe_oe_out);
`default_nettype wire

// file: tb/dbm_host_model.sv
// Host bus arbiter and requesting peripheral model
`default_nettype none
module dbm_host_model (
  input wire logic clk_in, // Clock
  input wire logic arst_n_in, // Reset, active low
  input wire logic loop_in, // Grant tied to request
  input wire logic hold_in, // Hold request
  input wire logic [3:0] ack_in, // Acks
  input wire logic ack_high_in, // Ack polarity
  input wire logic [3:0] want_in, // Start a request
  output logic grant_out, // Hold grant
  output logic [3:0] req_out // Channel requests
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] dly_r;
  assign grant_out = loop_in ? hold_in : dly_r[3];
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dly_r <= 4'h0;
      req_out <= 4'h0;
    end else begin
      dly_r <= {dly_r[2:0], hold_in};
      req_out <= (req_out | want_in) & ~(ack_in ^ {4{~ack_high_in}});
    end
  end
endmodule // dbm_host_model
`default_nettype wire

// file: tb/tb_dbm_top.sv
// Self-checking bench for the bus-master signalling block
`default_nettype none
module tb_dbm_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic loop = 1'b1;
  logic send = 1'b0;
  logic [3:0] want = 4'h0;
  dbm_pkg::dbm_ctrl_t ctrl = '0;
  dbm_pkg::dbm_addr_t addr = '0;
  wire logic grant, hold, uen, stb, moe, rd_n, wr_n, soe;
  wire logic [3:0] req, ack, mid;
  int miscompares = 0;
  int tests_run = 0;
  int nstb = 0;
  always #12.5 sys_clk_in = ~sys_clk_in;
  always @(posedge stb) nstb++;
  dbm_top i_dut (.sys_clk_in, .arst_n_in, .channel_request_in(req),
    .bus_hold_grant_in(grant), .ctrl_in(ctrl), .addr_in(addr),
    .service_end_in(send), .bus_hold_request_out(hold),
    .channel_acknowledge_out(ack), .upper_address_enable_out(uen),
    .upper_address_strobe_out(stb), .middle_address_out(mid),
    .middle_address_oe_out(moe), .memory_read_strobe_n_out(rd_n),
    .memory_write_strobe_n_out(wr_n), .mem_strobe_oe_out(soe));
  dbm_host_model i_host (.clk_in(sys_clk_in), .arst_n_in, .loop_in(loop),
    .hold_in(hold), .ack_in(ack), .ack_high_in(ctrl.ack_high),
    .want_in(want), .grant_out(grant), .req_out(req));
  // ==========
  // Tasks
  task automatic tk(input int n = 1);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic cmp(input logic [7:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_reset();
    cmp({hold, uen, moe, soe, rd_n, wr_n}, 8'h03, "reset drive");
    cmp(ack, 4'hf, "reset ack");
  endtask
  task automatic t_serv(input int ch, input dbm_pkg::dbm_xfer_t x,
      input logic ah, lp, chg, msk, sw);
    int i, gap, nrd, nwr;
    logic [3:0] on;
    on = 4'h1 << ch;
    nrd = 0;
    nwr = 0;
    for (i = 0; i < 20 && grant !== 1'b0; i++) tk();
    ctrl.xfer <= x;
    ctrl.ack_high <= ah;
    ctrl.mask <= msk ? on : 4'h0;
    loop <= lp;
    tk(3);
    nstb = 0;
    if (sw) ctrl.soft_req <= on;
    else want <= on;
    tk();
    want <= 4'h0;
    if (msk) begin
      tk(10);
      cmp(hold, 0, "masked request");
      ctrl.mask <= 4'h0;
    end
    for (i = 0; i < 20 && hold !== 1'b1; i++) tk();
    ctrl.soft_req <= 4'h0;
    for (gap = 0; gap < 20 && uen !== 1'b1; gap++) tk();
    if (lp) cmp(gap, 3, "hold wait");
    for (i = 0; i < 40 && hold === 1'b1; i++) begin
      if (i == 1 && chg) addr.upper <= addr.upper + 8'h01;
      if (i == 3) send <= 1'b1;
      if (uen === 1'b1) cmp(ack ^ {4{~ah}}, on, "ack");
      cmp(moe, uen, "mid drive");
      if (moe === 1'b1) cmp(mid, addr.middle, "mid addr");
      nrd += (rd_n === 1'b0);
      nwr += (wr_n === 1'b0);
      tk();
    end
    send <= 1'b0;
    cmp(ack, {4{~ah}}, "ack idle");
    cmp({uen, moe, soe}, 0, "idle drive");
    cmp(nrd, {x[1], 1'b0}, "reads");
    cmp(nwr, {x[0], 1'b0}, "writes");
    cmp(nstb, chg ? 2 : 1, "strobes");
  endtask
  // ==========
  // Sequence
  initial begin
    addr <= '{upper: 8'h5a, middle: 4'h9};
    tk(2);
    arst_n_in <= 1'b1;
    tk();
    t_reset();
    t_serv(0, dbm_pkg::DBM_XFER_READ, 0, 1, 0, 0, 0);
    t_serv(1, dbm_pkg::DBM_XFER_WRITE, 0, 0, 1, 0, 0);
    t_serv(2, dbm_pkg::DBM_XFER_MEM2MEM, 1, 1, 0, 0, 1);
    t_serv(3, dbm_pkg::DBM_XFER_VERIFY, 0, 0, 0, 1, 0);
    summarize();
  end
  initial begin
    #50us;
    miscompares++;
    summarize();
  end
endmodule // tb_dbm_top
`default_nettype wire
